// >>> hdl/pmc_pkg.sv
package pmc_pkg;

    // Debug register addresses on the two-wire debug port
    localparam logic [7:0] PMC_ADDR_PART_IDENTITY = 8'h00;
    localparam logic [7:0] PMC_ADDR_SILICON_REVISION = 8'h01;
    localparam logic [7:0] PMC_ADDR_CRC_RESULT_LOW = 8'ha9;
    localparam logic [7:0] PMC_ADDR_CRC_RESULT_SECOND = 8'haa;
    localparam logic [7:0] PMC_ADDR_CRC_RESULT_THIRD = 8'hab;
    localparam logic [7:0] PMC_ADDR_CRC_RESULT_HIGH = 8'hac;
    localparam logic [7:0] PMC_ADDR_CRC_STATUS = 8'had;

    // Identity codes; both values are arbitrary
    localparam logic [7:0] PMC_PART_IDENTITY_VALUE = 8'h5a;
    localparam logic [7:0] PMC_SILICON_REVISION_VALUE = 8'h03;

    // Reset values
    localparam logic [7:0] PMC_CRC_BYTE_RESET = 8'h00;
    localparam logic [7:0] PMC_RDATA_RESET = 8'h00;
    localparam logic [15:0] PMC_ADDR_RESET = 16'h0000;

    // Block and whole-memory geometry
    localparam logic [7:0] PMC_BLOCK_ADDR_LOW = 8'h00;
    localparam logic [16:0] PMC_BLOCK_BYTES = 17'h00100;
    localparam logic [16:0] PMC_PROG_MEM_BYTES = 17'h10000;
    localparam logic [15:0] PMC_WHOLE_START = 16'h0000;

    // Status register field positions
    localparam int PMC_STATUS_BUSY_BIT = 0;
    localparam int PMC_STATUS_WIDE_BIT = 1;

    // Checksum polynomials and seeds
    localparam logic [15:0] PMC_CRC16_POLY = 16'h1021;
    localparam logic [15:0] PMC_CRC16_SEED = 16'hffff;
    localparam logic [31:0] PMC_CRC32_POLY = 32'h04c11db7;
    localparam logic [31:0] PMC_CRC32_SEED = 32'hffffffff;

    // Checksum engine states, Gray coded along the walk
    typedef enum logic [1:0] {
        PMC_IDLE = 2'b00,
        PMC_FETCH = 2'b01,
        PMC_WAIT = 2'b11,
        PMC_DONE = 2'b10
    } pmc_state_type;

endpackage

// >>> hdl/pmc_crc_id_regs.sv
// Functional notes
// - Part identity byte is read-only.
// - Low CRC write starts 16-bit block check.
// - Written byte is block start address high.
// - Block start address low byte forced zero.
// - Block result: high second, low first register.
// - Second CRC write starts 32-bit whole check.
// - Whole check runs from address zero onward.
// - Whole result fills four bytes, low first.
module pmc_crc_id_regs
(
    input wire logic clk_sys, // System clock, 200 MHz
    input wire logic reset, // Synchronous reset, active high
    input wire logic [7:0] dbg_addr, // Register address from debug port
    input wire logic dbg_wr, // Write strobe, one cycle
    input wire logic [7:0] dbg_wdata, // Write data
    input wire logic dbg_rd, // Read strobe, one cycle
    output logic [7:0] dbg_rdata, // Read data
    output logic dbg_rvalid, // Read data valid, one cycle
    output logic [15:0] mem_addr, // Program memory byte address
    output logic mem_rd_en, // Program memory read request, one cycle
    input wire logic [7:0] mem_rd_data, // Program memory read data
    input wire logic mem_rd_valid, // Program memory data valid
    output logic crc_busy // Check in progress
);
    import pmc_pkg::*;

    // Byte-wise MSB-first update of the 16-bit checksum
    function automatic logic [15:0] pmc_crc16_step(input logic [15:0] crc, input logic [7:0] data);
        logic [15:0] acc;
        acc = crc;
        for (int i = 7; i >= 0; i--)
        begin
            if (acc[15] ^ data[i])
                acc = {acc[14:0], 1'b0} ^ PMC_CRC16_POLY;
            else
                acc = {acc[14:0], 1'b0};
        end
        return acc;
    endfunction

    // Byte-wise MSB-first update of the 32-bit checksum
    function automatic logic [31:0] pmc_crc32_step(input logic [31:0] crc, input logic [7:0] data);
        logic [31:0] acc;
        acc = crc;
        for (int i = 7; i >= 0; i--)
        begin
            if (acc[31] ^ data[i])
                acc = {acc[30:0], 1'b0} ^ PMC_CRC32_POLY;
            else
                acc = {acc[30:0], 1'b0};
        end
        return acc;
    endfunction

    // State and storage
    pmc_state_type state;
    pmc_state_type next_state;
    logic wide; // Current check is the 32-bit whole-memory one
    logic [16:0] remaining; // Bytes still to fetch
    logic [31:0] crc_acc; // Running checksum
    logic [7:0] crc_result_low;
    logic [7:0] crc_result_second;
    logic [7:0] crc_result_third;
    logic [7:0] crc_result_high;

    // Address decode of the debug register port
    wire logic hit_identity = (dbg_addr == PMC_ADDR_PART_IDENTITY);
    wire logic hit_revision = (dbg_addr == PMC_ADDR_SILICON_REVISION);
    wire logic hit_low = (dbg_addr == PMC_ADDR_CRC_RESULT_LOW);
    wire logic hit_second = (dbg_addr == PMC_ADDR_CRC_RESULT_SECOND);
    wire logic hit_third = (dbg_addr == PMC_ADDR_CRC_RESULT_THIRD);
    wire logic hit_high = (dbg_addr == PMC_ADDR_CRC_RESULT_HIGH);
    wire logic hit_status = (dbg_addr == PMC_ADDR_CRC_STATUS);

    // Starts are taken only while the engine is idle
    wire logic engine_idle = (state == PMC_IDLE);
    wire logic start_block = dbg_wr & hit_low & engine_idle;
    wire logic start_whole = dbg_wr & hit_second & engine_idle;
    wire logic start_any = start_block | start_whole;

    // Block start address: written byte high, low byte zero
    wire logic [15:0] block_start = {dbg_wdata, PMC_BLOCK_ADDR_LOW};
    wire logic [15:0] start_addr = start_block ? block_start : PMC_WHOLE_START;
    wire logic [16:0] start_count = start_block ? PMC_BLOCK_BYTES : PMC_PROG_MEM_BYTES;
    wire logic [31:0] start_seed = start_block ? {16'h0000, PMC_CRC16_SEED} : PMC_CRC32_SEED;

    // Next checksum once a fetched byte arrives
    wire logic [15:0] crc16_next = pmc_crc16_step(crc_acc[15:0], mem_rd_data);
    wire logic [31:0] crc32_next = pmc_crc32_step(crc_acc, mem_rd_data);
    wire logic [31:0] crc_next = wide ? crc32_next : {16'h0000, crc16_next};

    // Byte arrival and last-byte detection
    wire logic byte_in = (state == PMC_WAIT) & mem_rd_valid;
    wire logic last_byte = (remaining == 17'h00001);

    // Status byte: busy and mode bits at their fixed positions
    wire logic [7:0] busy_mask = 8'h01 << PMC_STATUS_BUSY_BIT;
    wire logic [7:0] wide_mask = 8'h01 << PMC_STATUS_WIDE_BIT;
    wire logic [7:0] status_byte = ({8{~engine_idle}} & busy_mask) | ({8{wide}} & wide_mask);

    // Read data selection; identity and revision are constants
    wire logic [7:0] read_mux =
        hit_identity ? PMC_PART_IDENTITY_VALUE :
        hit_revision ? PMC_SILICON_REVISION_VALUE :
        hit_low ? crc_result_low :
        hit_second ? crc_result_second :
        hit_third ? crc_result_third :
        hit_high ? crc_result_high :
        hit_status ? status_byte :
        PMC_RDATA_RESET;

    // Engine sequencing
    always_comb
    begin
        next_state = state;
        case (state)
            PMC_IDLE:
            begin
                if (start_any)
                    next_state = PMC_FETCH;
            end
            PMC_FETCH:
            begin
                next_state = PMC_WAIT;
            end
            PMC_WAIT:
            begin
                if (mem_rd_valid)
                    next_state = last_byte ? PMC_DONE : PMC_FETCH;
            end
            PMC_DONE:
            begin
                next_state = PMC_IDLE;
            end
            default:
            begin
                next_state = PMC_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            state <= PMC_IDLE;
        else
            state <= next_state;
    end

    // Next mode: set on every start, kept afterwards for the status byte
    wire logic next_wide = start_any ? start_whole : wide;

    // Next byte count and checksum: a start loads, each byte steps
    wire logic [16:0] next_remaining =
        start_any ? start_count :
        byte_in ? (remaining - 17'h00001) :
        remaining;
    wire logic [31:0] next_crc_acc =
        start_any ? start_seed :
        byte_in ? crc_next :
        crc_acc;

    // Check mode
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            wide <= 1'b0;
        else
            wide <= next_wide;
    end

    // Bytes still to fetch
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            remaining <= 17'h00000;
        else
            remaining <= next_remaining;
    end

    // Running checksum
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            crc_acc <= 32'h00000000;
        else
            crc_acc <= next_crc_acc;
    end

    // Next address: start address on a start, then one up per byte
    wire logic [15:0] next_mem_addr =
        start_any ? start_addr :
        byte_in ? (mem_addr + 16'h0001) :
        mem_addr;

    // Memory address register
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            mem_addr <= PMC_ADDR_RESET;
        else
            mem_addr <= next_mem_addr;
    end

    // Fetch request and busy flag follow the next state
    wire logic next_mem_rd_en = (next_state == PMC_FETCH);
    wire logic next_crc_busy = (next_state != PMC_IDLE);

    // One-cycle read request on entry to the fetch state
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            mem_rd_en <= 1'b0;
        else
            mem_rd_en <= next_mem_rd_en;
    end

    // Busy flag for the host to poll instead of a fixed wait
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            crc_busy <= 1'b0;
        else
            crc_busy <= next_crc_busy;
    end

    // Next result bytes; the finished result wins over a host store
    wire logic result_store = (state == PMC_DONE);
    wire logic wide_store = result_store & wide;
    wire logic [7:0] next_crc_result_low =
        result_store ? crc_acc[7:0] :
        start_block ? dbg_wdata :
        crc_result_low;
    wire logic [7:0] next_crc_result_second =
        result_store ? crc_acc[15:8] :
        start_whole ? dbg_wdata :
        crc_result_second;

    // Upper bytes load only on a whole-memory result
    wire logic [7:0] next_crc_result_third =
        wide_store ? crc_acc[23:16] : crc_result_third;
    wire logic [7:0] next_crc_result_high =
        wide_store ? crc_acc[31:24] : crc_result_high;

    // Low result byte: host start byte, then checksum low byte
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            crc_result_low <= PMC_CRC_BYTE_RESET;
        else
            crc_result_low <= next_crc_result_low;
    end

    // Second result byte
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            crc_result_second <= PMC_CRC_BYTE_RESET;
        else
            crc_result_second <= next_crc_result_second;
    end

    // Third result byte
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            crc_result_third <= PMC_CRC_BYTE_RESET;
        else
            crc_result_third <= next_crc_result_third;
    end

    // High result byte
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            crc_result_high <= PMC_CRC_BYTE_RESET;
        else
            crc_result_high <= next_crc_result_high;
    end

    // Read data holds until the next read
    wire logic [7:0] next_dbg_rdata = dbg_rd ? read_mux : dbg_rdata;

    // Read data register
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            dbg_rdata <= PMC_RDATA_RESET;
        else
            dbg_rdata <= next_dbg_rdata;
    end

    // Read valid pulse, one cycle after the strobe
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            dbg_rvalid <= 1'b0;
        else
            dbg_rvalid <= dbg_rd;
    end

endmodule

// >>> testbench/pmc_mem_model.sv
module pmc_mem_model
(
    input wire logic clk_sys, // Clock
    input wire logic reset, // Sync reset
    input wire logic [15:0] mem_addr, // Fetch address
    input wire logic mem_rd_en, // Fetch request
    output logic [7:0] mem_rd_data, // Byte
    output logic mem_rd_valid // Byte valid
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] wait_cnt = 3'h0;
    logic [15:0] held = 16'h0000;

    // Answer each fetch, odd addresses slowly; idle data keeps toggling
    initial
    begin
        mem_rd_valid = 1'b0;
        mem_rd_data = 8'h00;
        forever
        begin
            @(negedge clk_sys);
            mem_rd_valid = (wait_cnt == 3'h1);
            mem_rd_data = mem_rd_valid ? held[7:0] ^ held[15:8] ^ 8'h3c : ~mem_rd_data;
            if (reset)
                wait_cnt = 3'h0;
            else if (mem_rd_en)
            begin
                held = mem_addr;
                wait_cnt = mem_addr[0] ? 3'h4 : 3'h1;
            end
            else if (wait_cnt != 3'h0)
                wait_cnt = wait_cnt - 3'h1;
        end
    end
endmodule

// >>> testbench/pmc_crc_id_regs_assertions.sv
module pmc_crc_id_regs_assertions
(
    input wire logic clk_sys, // Clock
    input wire logic reset, // Sync reset
    input wire logic [7:0] dbg_addr, // Address
    input wire logic dbg_wr, // Write strobe
    input wire logic [7:0] dbg_wdata, // Write data
    input wire logic dbg_rd, // Read strobe
    input wire logic [7:0] dbg_rdata, // Read data
    input wire logic dbg_rvalid, // Read valid
    input wire logic [15:0] mem_addr, // Fetch address
    input wire logic mem_rd_en, // Fetch request
    input wire logic crc_busy // Check running
);
    timeunit 1ns;
    timeprecision 1ps;
    import pmc_pkg::*;
    logic [15:0] last_addr;
    logic [16:0] req_cnt;
    logic wide;
    logic start;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);

    // A check is accepted only while idle
    assign start = dbg_wr && !crc_busy && (dbg_addr == PMC_ADDR_CRC_RESULT_LOW
        || dbg_addr == PMC_ADDR_CRC_RESULT_SECOND);

    // Last fetch address, fetch count and mode of the running check
    always_ff @(posedge clk_sys)
    begin
        if (mem_rd_en)
            last_addr <= mem_addr;
        if (reset || start)
            req_cnt <= 17'h00000;
        else if (mem_rd_en)
            req_cnt <= req_cnt + 17'h00001;
        if (start)
            wide <= (dbg_addr == PMC_ADDR_CRC_RESULT_SECOND);
    end

    AST_READ_ACK: assert property (dbg_rd |=> dbg_rvalid)
        else $error("read not acknowledged");
    AST_ID_VALUE: assert property (dbg_rd && dbg_addr == PMC_ADDR_PART_IDENTITY
        |=> dbg_rdata == PMC_PART_IDENTITY_VALUE) else $error("identity wrong");
    AST_REV_VALUE: assert property (dbg_rd && dbg_addr == PMC_ADDR_SILICON_REVISION
        |=> dbg_rdata == PMC_SILICON_REVISION_VALUE) else $error("revision wrong");
    AST_BLOCK_START: assert property (start && dbg_addr == PMC_ADDR_CRC_RESULT_LOW
        |=> crc_busy && mem_rd_en && mem_addr == {$past(dbg_wdata), 8'h00})
        else $error("block start wrong");
    AST_WHOLE_START: assert property (start && dbg_addr == PMC_ADDR_CRC_RESULT_SECOND
        |=> crc_busy && mem_rd_en && mem_addr == 16'h0000) else $error("whole start wrong");
    AST_IDLE_QUIET: assert property (!crc_busy |-> !mem_rd_en)
        else $error("fetch while idle");
    AST_ADDR_STEP: assert property (mem_rd_en && $past(crc_busy)
        |-> mem_addr == last_addr + 16'h0001) else $error("fetch address skipped");
    AST_BLOCK_LEN: assert property ($fell(crc_busy) && !wide
        |-> req_cnt == 17'h00100) else $error("block length wrong");
endmodule

bind pmc_crc_id_regs pmc_crc_id_regs_assertions i_pmc_crc_id_regs_assertions
(
    .clk_sys(clk_sys), .reset(reset), .dbg_addr(dbg_addr), .dbg_wr(dbg_wr),
    .dbg_wdata(dbg_wdata), .dbg_rd(dbg_rd), .dbg_rdata(dbg_rdata), .dbg_rvalid(dbg_rvalid),
    .mem_addr(mem_addr), .mem_rd_en(mem_rd_en), .crc_busy(crc_busy)
);

// >>> testbench/tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import pmc_pkg::*;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic [7:0] dbg_addr = 8'h00;
    logic dbg_wr = 1'b0;
    logic [7:0] dbg_wdata = 8'h00;
    logic dbg_rd = 1'b0;
    logic [7:0] dbg_rdata;
    logic dbg_rvalid;
    logic [15:0] mem_addr;
    logic mem_rd_en;
    logic [7:0] mem_rd_data;
    logic mem_rd_valid;
    logic crc_busy;
    logic [7:0] got;
    int errors = 0;
    int total_checks = 0;

    pmc_crc_id_regs i_pmc_crc_id_regs
    (
        .clk_sys(clk_sys), .reset(reset), .dbg_addr(dbg_addr), .dbg_wr(dbg_wr),
        .dbg_wdata(dbg_wdata), .dbg_rd(dbg_rd), .dbg_rdata(dbg_rdata),
        .dbg_rvalid(dbg_rvalid), .mem_addr(mem_addr), .mem_rd_en(mem_rd_en),
        .mem_rd_data(mem_rd_data), .mem_rd_valid(mem_rd_valid), .crc_busy(crc_busy)
    );
    pmc_mem_model i_pmc_mem_model
    (
        .clk_sys(clk_sys), .reset(reset), .mem_addr(mem_addr), .mem_rd_en(mem_rd_en),
        .mem_rd_data(mem_rd_data), .mem_rd_valid(mem_rd_valid)
    );

    // 200 MHz clock
    initial
        forever #2.5 clk_sys = ~clk_sys;

    // Compare and count
    task chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e)
        begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // Register port cycles, one strobe cycle each
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        dbg_addr = a;
        dbg_wdata = d;
        dbg_wr = 1'b1;
        @(negedge clk_sys);
        dbg_wr = 1'b0;
    endtask
    task rd(input logic [7:0] a, output logic [7:0] v);
        @(negedge clk_sys);
        dbg_addr = a;
        dbg_rd = 1'b1;
        @(negedge clk_sys);
        dbg_rd = 1'b0;
        v = (dbg_rvalid === 1'b1) ? dbg_rdata : 8'hxx;
    endtask

    // Expected block checksum over the model's byte pattern
    function automatic logic [15:0] crc16(input logic [15:0] base);
        logic [15:0] c;
        logic [15:0] a;
        c = PMC_CRC16_SEED;
        for (int i = 0; i < 256; i++)
        begin
            a = base + i[15:0];
            c = c ^ {a[7:0] ^ a[15:8] ^ 8'h3c, 8'h00};
            for (int b = 0; b < 8; b++)
                c = c[15] ? ((c << 1) ^ PMC_CRC16_POLY) : (c << 1);
        end
        return c;
    endfunction

    task t_ident;
        wr(PMC_ADDR_PART_IDENTITY, 8'hff);
        rd(PMC_ADDR_PART_IDENTITY, got);
        chk(got, PMC_PART_IDENTITY_VALUE);
        rd(PMC_ADDR_SILICON_REVISION, got);
        chk(got, PMC_SILICON_REVISION_VALUE);
        rd(8'h55, got);
        chk(got, 8'h00);
    endtask

    // Block check; a second start while busy must be ignored
    task t_block(input logic [7:0] hi);
        logic [15:0] e;
        int n;
        e = crc16({hi, 8'h00});
        wr(PMC_ADDR_CRC_RESULT_LOW, hi);
        chk(mem_addr, {hi, 8'h00});
        chk(crc_busy, 1'b1);
        rd(PMC_ADDR_CRC_STATUS, got);
        chk(got, 32'h1 << PMC_STATUS_BUSY_BIT);
        wr(PMC_ADDR_CRC_RESULT_LOW, ~hi);
        n = 0;
        while (crc_busy !== 1'b0 && n < 4000)
        begin
            @(negedge clk_sys);
            n++;
        end
        chk(crc_busy, 1'b0);
        rd(PMC_ADDR_CRC_RESULT_LOW, got);
        chk(got, e[7:0]);
        rd(PMC_ADDR_CRC_RESULT_SECOND, got);
        chk(got, e[15:8]);
        rd(PMC_ADDR_CRC_RESULT_THIRD, got);
        chk(got, PMC_CRC_BYTE_RESET);
        rd(PMC_ADDR_CRC_RESULT_HIGH, got);
        chk(got, PMC_CRC_BYTE_RESET);
        rd(PMC_ADDR_CRC_STATUS, got);
        chk(got, 8'h00);
    endtask

    // Whole check starts at zero and runs on; aborted by reset
    task t_whole;
        wr(PMC_ADDR_CRC_RESULT_SECOND, 8'h77);
        chk(mem_addr, 16'h0000);
        repeat (300) @(negedge clk_sys);
        chk(crc_busy, 1'b1);
        rd(PMC_ADDR_CRC_STATUS, got);
        chk(got, (32'h1 << PMC_STATUS_BUSY_BIT) | (32'h1 << PMC_STATUS_WIDE_BIT));
        reset = 1'b1;
        repeat (5) @(negedge clk_sys);
        reset = 1'b0;
        chk(crc_busy, 1'b0);
        rd(PMC_ADDR_CRC_RESULT_SECOND, got);
        chk(got, PMC_CRC_BYTE_RESET);
    endtask

    task results;
        $display("errors=%0d checks=%0d", errors, total_checks);
        if (errors == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        repeat (5) @(posedge clk_sys);
        @(negedge clk_sys);
        reset = 1'b0;
        t_ident;
        t_block(8'h12);
        t_whole;
        t_block(8'hff);
        results;
    end

    // Watchdog, far beyond the few thousand cycles needed
    initial
    begin
        #100000;
        errors++;
        results;
    end
endmodule
